/* File: hw/rtc_link_pkg.sv */
package rtc_link_pkg;

  // ----------------------------------------------------------------
  // Bus identity and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  localparam logic RW_READ = 1'h1;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 4;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [7:0] IDLE_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Watchdog timing, counted in 1 Hz ticks
  // ----------------------------------------------------------------
  localparam int TIMEOUT_MIN_S = 1;
  localparam int TIMEOUT_MAX_S = 2;
  // The first tick may land right after the address, so the limit is
  // reached on the tick numbered by the longest time: 1 s to 2 s.
  localparam logic [1:0] TIMEOUT_TICKS = 2'(TIMEOUT_MAX_S);

  // ----------------------------------------------------------------
  // Write buffer
  // ----------------------------------------------------------------
  localparam int WFIFO_DEPTH = 4;
  localparam int WFIFO_WIDTH = PTR_W + BYTE_W;

  // ----------------------------------------------------------------
  // Serial engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_wptr,
    st_wdata,
    st_read,
    st_lapsed
  } link_state_type;

endpackage : rtc_link_pkg

/* File: hw/rtc_i2c_slave_access.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Small flop FIFO for register writes
// ------------------------------------------------------------------
module rtc_write_fifo #(
  parameter int WIDTH = rtc_link_pkg::WFIFO_WIDTH,
  parameter int DEPTH = rtc_link_pkg::WFIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Index wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("rtc_write_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("rtc_write_fifo: WIDTH must be positive");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] fill;
  wire do_push;
  wire do_pop;

  // Handshakes straight from the fill level
  assign in_ready = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;
  assign out_data = store[rd_idx];

  // Pointers and fill count
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill <= '0;
    end else begin
      if (do_push) wr_idx <= wr_idx + 1'b1;
      if (do_pop) rd_idx <= rd_idx + 1'b1;
      fill <= fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Storage needs no reset; nothing reads an empty slot
  always_ff @(posedge mclk) begin
    if (do_push) store[wr_idx] <= in_data;
  end
endmodule : rtc_write_fifo

// ------------------------------------------------------------------
// Serial slave port of the clock
// ------------------------------------------------------------------
module rtc_i2c_slave_access (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic tick_1hz,
  output logic time_tick,
  output logic freeze,
  output logic timeout_pulse,
  output logic [rtc_link_pkg::PTR_W-1:0] reg_addr,
  input wire logic [rtc_link_pkg::BYTE_W-1:0] reg_rdata,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [rtc_link_pkg::PTR_W-1:0] wr_addr,
  output logic [rtc_link_pkg::BYTE_W-1:0] wr_data
);
  // ----------------------------------------------------------------
  // Input synchronisers and filters
  // ----------------------------------------------------------------
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] tick_sync;
  logic scl_r;
  logic sda_r;
  logic tick_r;
  logic scl_prev;
  logic sda_prev;
  logic tick_prev;

  // Three stages; a level is taken only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      tick_sync <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      tick_sync <= {tick_sync[1:0], tick_1hz};
    end
  end

  // Filtered levels and their previous values
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      scl_r <= 1'h1;
      sda_r <= 1'h1;
      tick_r <= 1'h0;
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
      tick_prev <= 1'h0;
    end else begin
      if (scl_sync[1] == scl_sync[2]) scl_r <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda_r <= sda_sync[2];
      if (tick_sync[1] == tick_sync[2]) tick_r <= tick_sync[2];
      scl_prev <= scl_r;
      sda_prev <= sda_r;
      tick_prev <= tick_r;
    end
  end

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  wire clk_high = scl_r & scl_prev;
  wire start_det = clk_high & sda_prev & ~sda_r;
  wire stop_det = clk_high & ~sda_prev & sda_r;
  wire scl_rise = scl_r & ~scl_prev;
  wire scl_fall = ~scl_r & scl_prev;
  wire tick_rise = tick_r & ~tick_prev;

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  rtc_link_pkg::link_state_type state;
  logic [3:0] bit_cnt;
  logic [rtc_link_pkg::BYTE_W-1:0] rx_shift;
  logic [rtc_link_pkg::BYTE_W-1:0] tx_shift;
  logic [rtc_link_pkg::PTR_W-1:0] ptr;
  logic dir_read;
  logic addr_ok;
  logic master_ack;
  logic active;
  logic push_valid;
  logic [rtc_link_pkg::WFIFO_WIDTH-1:0] push_data;
  logic [1:0] wd_ticks;
  logic tick_pend;
  logic push_ready;
  logic mid_bit;

  // Byte boundaries on the falling clock edge.
  // Only a fall that follows a rise closes a bit; the fall that ends a
  // START or repeated START carries no bit and must not move the count,
  // or every byte after it would end one clock early.
  wire byte_end = scl_fall & mid_bit & (bit_cnt == rtc_link_pkg::LAST_DATA_BIT);
  wire ack_end = scl_fall & mid_bit & (bit_cnt == rtc_link_pkg::ACK_BIT);
  wire in_byte = (bit_cnt < rtc_link_pkg::LAST_DATA_BIT);
  wire addr_hit = (rx_shift[7:1] == rtc_link_pkg::SLAVE_ADDR);
  wire timeout = active & tick_rise & (wd_ticks == rtc_link_pkg::TIMEOUT_TICKS - 2'h1);
  wire engaged = (state != rtc_link_pkg::st_idle) && (state != rtc_link_pkg::st_lapsed);
  wire [rtc_link_pkg::PTR_W-1:0] ptr_next = ptr + 1'b1;

  // Bit counter and receive shifter; mid_bit marks a clock high phase seen
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bit_cnt <= rtc_link_pkg::FIRST_BIT;
      rx_shift <= '0;
      master_ack <= 1'h0;
      mid_bit <= 1'h0;
    end else if (start_det) begin
      bit_cnt <= rtc_link_pkg::FIRST_BIT;
      mid_bit <= 1'h0;
    end else if (engaged && scl_rise) begin
      // Sample on rising clock; data is stable while high
      mid_bit <= 1'h1;
      if (bit_cnt != rtc_link_pkg::ACK_BIT) rx_shift <= {rx_shift[6:0], sda_r};
      else master_ack <= ~sda_r;
    end else if (engaged && scl_fall && mid_bit) begin
      // Bit closed: next fall counts only after another rise
      mid_bit <= 1'h0;
      bit_cnt <= ack_end ? rtc_link_pkg::FIRST_BIT : bit_cnt + 4'h1;
    end
  end

  // Main sequencing: framing, address match, pointer and direction
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= rtc_link_pkg::st_idle;
      ptr <= '0;
      dir_read <= 1'h0;
      addr_ok <= 1'h0;
      active <= 1'h0;
    end else if (start_det) begin
      // Repeated START closes the old access first
      state <= rtc_link_pkg::st_addr;
      addr_ok <= 1'h0;
      active <= 1'h0;
    end else if (stop_det) begin
      state <= rtc_link_pkg::st_idle;
      active <= 1'h0;
    end else if (timeout) begin
      state <= rtc_link_pkg::st_lapsed;
      active <= 1'h0;
    end else if (byte_end) begin
      unique case (state)
        rtc_link_pkg::st_addr: begin
          if (addr_hit) begin
            addr_ok <= 1'h1;
            active <= 1'h1;
            dir_read <= (rx_shift[0] == rtc_link_pkg::RW_READ);
          end else begin
            state <= rtc_link_pkg::st_idle;
          end
        end
        rtc_link_pkg::st_wptr: ptr <= rx_shift[rtc_link_pkg::PTR_W-1:0];
        rtc_link_pkg::st_wdata: ptr <= ptr_next;
        rtc_link_pkg::st_read: ptr <= ptr_next;
        rtc_link_pkg::st_idle, rtc_link_pkg::st_lapsed: ;
      endcase
    end else if (ack_end) begin
      unique case (state)
        rtc_link_pkg::st_addr: begin
          if (addr_ok) state <= dir_read ? rtc_link_pkg::st_read : rtc_link_pkg::st_wptr;
        end
        rtc_link_pkg::st_wptr: state <= rtc_link_pkg::st_wdata;
        // No ack from master: stop sending, wait for STOP or START
        rtc_link_pkg::st_read: if (!master_ack) state <= rtc_link_pkg::st_idle;
        rtc_link_pkg::st_wdata, rtc_link_pkg::st_idle, rtc_link_pkg::st_lapsed: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data line driver: ack pulls and read bits
  // ----------------------------------------------------------------
  // All changes but the timeout release happen on the falling clock, so the line is steady while high
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sda_oe <= 1'h0;
      tx_shift <= rtc_link_pkg::IDLE_BYTE;
    end else if (start_det || stop_det || timeout) begin
      sda_oe <= 1'h0;
    end else if (byte_end) begin
      // Ack a matching address and every pointer or data byte; in a read, let the master answer
      unique case (state)
        rtc_link_pkg::st_addr: sda_oe <= addr_hit;
        rtc_link_pkg::st_wptr, rtc_link_pkg::st_wdata: sda_oe <= 1'h1;
        rtc_link_pkg::st_read, rtc_link_pkg::st_idle, rtc_link_pkg::st_lapsed: sda_oe <= 1'h0;
      endcase
    end else if (ack_end) begin
      // Load the next byte from the current pointer
      if ((state == rtc_link_pkg::st_addr && addr_ok && dir_read) ||
          (state == rtc_link_pkg::st_read && master_ack)) begin
        tx_shift <= reg_rdata;
        sda_oe <= ~reg_rdata[7];
      end else begin
        sda_oe <= 1'h0;
      end
    end else if (scl_fall && mid_bit && state == rtc_link_pkg::st_read && in_byte) begin
      // Next bit goes out one fall after its predecessor was sampled
      tx_shift <= {tx_shift[6:0], 1'h1};
      sda_oe <= ~tx_shift[6];
    end
  end

  // ----------------------------------------------------------------
  // Write path into the buffer
  // ----------------------------------------------------------------
  // A full buffer holds the clock low rather than lose a byte
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      push_valid <= 1'h0;
      push_data <= '0;
    end else if (byte_end && state == rtc_link_pkg::st_wdata && !timeout) begin
      push_valid <= 1'h1;
      push_data <= {ptr, rx_shift};
    end else if (push_ready) begin
      push_valid <= 1'h0;
    end
  end

  rtc_write_fifo #(
    .WIDTH(rtc_link_pkg::WFIFO_WIDTH),
    .DEPTH(rtc_link_pkg::WFIFO_DEPTH)
  ) u_wfifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  // ----------------------------------------------------------------
  // Freeze, watchdog and tick release
  // ----------------------------------------------------------------
  // Watchdog restarts at every matching address
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wd_ticks <= 2'h0;
    end else if (!active || (byte_end && state == rtc_link_pkg::st_addr)) begin
      wd_ticks <= 2'h0;
    end else if (tick_rise) begin
      wd_ticks <= wd_ticks + 2'h1;
    end
  end

  // A tick during an access is held and given back at its end.
  // On timeout the held tick is dropped, so one second is lost.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_pend <= 1'h0;
      time_tick <= 1'h0;
      timeout_pulse <= 1'h0;
    end else begin
      timeout_pulse <= timeout;
      if (timeout) begin
        tick_pend <= 1'h0;
        time_tick <= 1'h1;
      end else if (active) begin
        if (tick_rise) tick_pend <= 1'h1;
        time_tick <= 1'h0;
      end else begin
        tick_pend <= 1'h0;
        time_tick <= tick_rise | tick_pend;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin and status outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pull low
  assign sda_out = 1'h0;
  assign scl_out = 1'h0;
  assign scl_oe = push_valid & ~push_ready;
  assign freeze = active;
  assign reg_addr = ptr;
endmodule : rtc_i2c_slave_access

/* File: sim/rtc_i2c_slave_access_chk.sv */
`timescale 1ns/1ps
module rtc_i2c_slave_access_chk (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic tick_1hz,
  input wire logic time_tick,
  input wire logic freeze,
  input wire logic timeout_pulse,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [rtc_link_pkg::PTR_W-1:0] wr_addr,
  input wire logic [rtc_link_pkg::BYTE_W-1:0] wr_data
);
  // --------
  // Bus pins and write port
  // --------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Open drain: only ever pull low
  property p_open_drain;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("bus pin driven high");
  // Data moves only with clock low, timeout release excepted
  property p_sda_change;
    $changed(sda_oe) && !timeout_pulse && !$past(timeout_pulse) |-> !scl_in;
  endproperty
  a_sda_change: assert property (p_sda_change)
    else $error("data changed while clock high");
  property p_ack_addr;
    $rose(freeze) |-> ##[0:1] sda_oe;
  endproperty
  a_ack_addr: assert property (p_ack_addr)
    else $error("address taken without ack");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write entry changed before taken");

  // --------
  // Time keeping
  // --------
  property p_tick_pulse;
    time_tick |=> !time_tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("time tick longer than one cycle");
  property p_frozen;
    freeze && $past(freeze) |-> !time_tick;
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("time advanced during access");
  property p_tick_pass;
    $rose(tick_1hz) && !freeze |-> ##[1:10] (time_tick || freeze);
  endproperty
  a_tick_pass: assert property (p_tick_pass)
    else $error("idle tick not passed on");
  property p_tmo_pulse;
    timeout_pulse |=> !timeout_pulse;
  endproperty
  a_tmo_pulse: assert property (p_tmo_pulse)
    else $error("timeout pulse too long");
  property p_tmo_release;
    timeout_pulse |-> ##[0:1] !freeze;
  endproperty
  a_tmo_release: assert property (p_tmo_release)
    else $error("timeout left counters frozen");
  property p_tmo_loss;
    timeout_pulse |-> ##[0:8] time_tick;
  endproperty
  a_tmo_loss: assert property (p_tmo_loss)
    else $error("no single tick after timeout");

  c_timeout: cover property (timeout_pulse);
  c_stretch: cover property (scl_oe);
  c_drain: cover property (wr_valid && wr_ready);
  c_access: cover property ($rose(freeze));
endmodule : rtc_i2c_slave_access_chk

bind rtc_i2c_slave_access rtc_i2c_slave_access_chk chk (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .tick_1hz(tick_1hz), .time_tick(time_tick),
  .freeze(freeze), .timeout_pulse(timeout_pulse), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data)
);

/* File: sim/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int T_LOW = 1300,
  parameter int T_HIGH = 700
) (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  // Both lines released at rest; pull-ups make them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // One clock pulse; waiting for the line honours stretching
  task automatic clk_bit(input logic b, output logic r);
    #(T_LOW / 4);
    sda_low = ~b;
    #(T_LOW - T_LOW / 4);
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #(T_HIGH / 2);
    r = sda_line;
    #(T_HIGH / 2);
    r = r | sda_line;
    scl_low = 1'b1;
  endtask : clk_bit

  // Also a repeated start when entered with clock low
  task automatic start;
    #(T_LOW / 4);
    sda_low = 1'b0;
    #(T_LOW);
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #(T_HIGH);
    sda_low = 1'b1;
    #(T_HIGH);
    scl_low = 1'b1;
  endtask : start

  task automatic stop;
    #(T_LOW / 4);
    sda_low = 1'b1;
    #(T_LOW);
    scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #(T_HIGH);
    sda_low = 1'b0;
    #(T_LOW);
  endtask : stop

  // Eight bits MSB first plus ack clock; a=1 withholds ack on reads
  task automatic xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(a, r);
  endtask : xb
endmodule : i2c_master_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic tick_1hz = 1'b0;
  logic wr_ready = 1'b0;
  logic stall = 1'b0;
  logic scl_low, sda_low, scl_oe, sda_oe, scl_out, sda_out, ack;
  logic time_tick, freeze, timeout_pulse, wr_valid;
  logic [3:0] reg_addr, wr_addr;
  logic [7:0] wr_data, q;
  logic [7:0] regs [16];
  int err_total = 0;
  int n_tests = 0;
  int n_tt = 0;
  int n_to = 0;
  wire scl_line = ~(scl_low | scl_oe);
  wire sda_line = ~(sda_low | sda_oe);
  wire [7:0] reg_rdata = regs[reg_addr];

  // --------
  // Clock, core side and instances
  // --------
  always #12.5 mclk = ~mclk;
  // Core drains the write buffer and counts pulses, which are only one cycle
  always @(posedge mclk) begin
    wr_ready <= ~stall;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) regs[wr_addr] <= wr_data;
    if (time_tick === 1'b1) n_tt <= n_tt + 1;
    if (timeout_pulse === 1'b1) n_to <= n_to + 1;
  end
  i2c_master_model mst (.scl_line(scl_line), .sda_line(sda_line),
    .scl_low(scl_low), .sda_low(sda_low));
  rtc_i2c_slave_access dut (.mclk(mclk), .reset_n(reset_n), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .tick_1hz(tick_1hz), .time_tick(time_tick), .freeze(freeze),
    .timeout_pulse(timeout_pulse), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data));

  // --------
  // Helpers
  // --------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic pulse_tick;
    @(posedge mclk) tick_1hz <= 1'b1;
    repeat (4) @(posedge mclk);
    tick_1hz <= 1'b0;
    repeat (20) @(posedge mclk);
  endtask : pulse_tick
  task automatic conclude;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // --------
  // Scenarios
  // --------
  // Five bytes into a stalled four-entry buffer forces clock stretching
  task automatic test_write;
    int t0;
    t0 = n_tt;
    pulse_tick();
    check(8'(n_tt - t0), 8'h01);
    @(posedge mclk) stall <= 1'b1;
    mst.start();
    mst.xb(8'ha2, 1'b1, q, ack);
    check(ack, 1'b0);
    check(freeze, 1'b1);
    t0 = n_tt;
    pulse_tick();
    mst.xb(8'hf3, 1'b1, q, ack);
    check(ack, 1'b0);
    fork
      for (int i = 0; i < 5; i++) begin
        mst.xb(8'h40 + 8'(i), 1'b1, q, ack);
        check(ack, 1'b0);
      end
      begin
        for (int k = 0; k < 9000 && scl_oe !== 1'b1; k++) @(posedge mclk);
        repeat (100) @(posedge mclk);
        check(scl_line, 1'b0);
        stall <= 1'b0;
      end
    join
    check(8'(n_tt - t0), 8'h00);
    mst.stop();
    repeat (20) @(posedge mclk);
    check(8'(n_tt - t0), 8'h01);
    for (int i = 0; i < 5; i++) check(regs[3 + i], 8'h40 + 8'(i));
    $display("write test done");
  endtask : test_write

  // Pointer write, repeated start, two reads, then a read with no pointer
  task automatic test_read;
    mst.start();
    mst.xb(8'ha2, 1'b1, q, ack);
    mst.xb(8'h03, 1'b1, q, ack);
    check(ack, 1'b0);
    mst.start();
    mst.xb(8'ha3, 1'b1, q, ack);
    check(ack, 1'b0);
    mst.xb(8'hff, 1'b0, q, ack);
    check(q, regs[3]);
    mst.xb(8'hff, 1'b1, q, ack);
    check(q, regs[4]);
    repeat (60) @(posedge mclk);
    check(sda_oe, 1'b0);
    mst.stop();
    mst.start();
    mst.xb(8'ha3, 1'b1, q, ack);
    mst.xb(8'hff, 1'b1, q, ack);
    check(q, regs[5]);
    mst.stop();
    $display("read test done");
  endtask : test_read

  // Near misses, including the own address sent LSB first
  task automatic test_foreign;
    logic [7:0] adr [4];
    adr = '{8'ha0, 8'ha6, 8'he2, 8'h8a};
    foreach (adr[i]) begin
      mst.start();
      mst.xb(adr[i], 1'b1, q, ack);
      check(ack, 1'b1);
      mst.xb(8'h00, 1'b1, q, ack);
      check(ack, 1'b1);
      check(freeze, 1'b0);
      mst.stop();
    end
    $display("foreign test done");
  endtask : test_foreign

  // Stalled read cleared on the second tick; only a new start recovers
  task automatic test_timeout;
    int t0;
    int k0;
    mst.start();
    mst.xb(8'ha3, 1'b1, q, ack);
    t0 = n_tt;
    k0 = n_to;
    pulse_tick();
    check(8'(n_to - k0), 8'h00);
    pulse_tick();
    check(8'(n_to - k0), 8'h01);
    check(freeze, 1'b0);
    check(8'(n_tt - t0), 8'h01);
    mst.xb(8'hff, 1'b1, q, ack);
    check(q, 8'hff);
    mst.start();
    mst.xb(8'ha2, 1'b1, q, ack);
    check(ack, 1'b0);
    mst.stop();
    $display("timeout test done");
  endtask : test_timeout

  // --------
  // Main sequence and watchdog
  // --------
  initial begin
    for (int i = 0; i < 16; i++) regs[i] = 8'(i * 37 + 5);
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    test_write();
    test_read();
    test_foreign();
    test_timeout();
    conclude();
  end
  // A hung bus never finishes; cut the run well past the expected length
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
endmodule : tb
